/* File: design/msl_cfg.svh */
// Purpose: constants of the mode, sync and lock-pin control block
// Assumes: 32-bit serial frames, address in the low five bits
// Notes: field positions, mode, pin and sync source codes and the sync enable reset value live here
//
// How it works
// - five-bit mode field selects dual loop, single loop or distribution; others reserved.
// - single-loop modes run only loop two, loop one off, oscillator is reference.
// - distribution routes reference two to the groups, oscillator to buffer and groups 3-4.
// - synchronization works only while the enable bit is set; it resets set.
// - enable bit rising from 0 to 1 raises a sync event; masked groups ignore it.
// - one mask bit per group, bits 20..25; set means the group keeps running.
// - while sync is asserted every unmasked group is held low.
// - a new digital delay takes effect only through a sync, never when masked.
// - setting a mask bit leaves already synchronized groups undisturbed.
// - sync pin output source is low or readback; type 3 plain, 4 inverted.
// - qualification times sync on/off with the feedback-selected output; keeps group 2 divider.
// - sync pin input is active high with polarity 0, active low with 1.
// - writing the polarity bit alone asserts and releases sync.
// - auto bit set makes any write to registers 0..5 raise a sync.
// - an automatic sync lines up with the falling edge of latch enable.
// - three-bit sync pin kind: inputs, pulls, push-pull, inverted, open source, open drain.
// - sync pin as output forces internal sync input to 0.
// - crystal amplifier runs only while its enable bit is set.
// - five-bit lock pin source: lock detects, holdover, converter flags, divider monitors.
// - lock pin drives source plain for kind 3, inverted for kind 4.
// - zero-delay loop modes give outputs fixed phase to the reference.
// - feedback selector codes 0..5 pick groups, 6 the external feedback input.
`ifndef MSL_CFG_SVH
`define MSL_CFG_SVH

// ---------------------------------------------------------------
// addresses
// ---------------------------------------------------------------
`define MSL_ADDR_MODE_SYNC 5'h0B
`define MSL_ADDR_LOCK_PIN 5'h0C
`define MSL_ADDR_DIV_LAST 5'h05

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define MSL_MODE_HI 31
`define MSL_MODE_LO 27
`define MSL_EN_BIT 26
`define MSL_MASK_HI 25
`define MSL_MASK_LO 20
`define MSL_SRC_HI 19
`define MSL_SRC_LO 18
`define MSL_QUAL_BIT 17
`define MSL_POL_BIT 16
`define MSL_AUTO_BIT 15
`define MSL_STYPE_HI 14
`define MSL_STYPE_LO 12
`define MSL_XTAL_BIT 5
`define MSL_LDSRC_HI 31
`define MSL_LDSRC_LO 27
`define MSL_LDTYPE_HI 26
`define MSL_LDTYPE_LO 24

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define MSL_RST_SYNC_EN 1'b1
`define MSL_RST_ZERO5 5'h00
`define MSL_RST_ZERO3 3'h0

// ---------------------------------------------------------------
// codes
// ---------------------------------------------------------------
`define MSL_MODE_DUAL_INT 5'h00
`define MSL_MODE_DUAL_INT_ZD 5'h02
`define MSL_MODE_DUAL_EXT 5'h03
`define MSL_MODE_DUAL_EXT_ZD 5'h05
`define MSL_MODE_SGL_INT 5'h06
`define MSL_MODE_SGL_INT_ZD 5'h08
`define MSL_MODE_SGL_EXT 5'h0B
`define MSL_MODE_DISTRIB 5'h10
`define MSL_PIN_IN_PU 3'h1
`define MSL_PIN_IN_PD 3'h2
`define MSL_PIN_OUT 3'h3
`define MSL_PIN_OUT_INV 3'h4
`define MSL_PIN_OPEN_SRC 3'h5
`define MSL_PIN_OPEN_DRN 3'h6
`define MSL_SSRC_LOW 2'h0
`define MSL_SSRC_READBACK 2'h3
`define MSL_LD_DIV_FIRST 5'h0B
`define MSL_LD_DIV_LAST 5'h12
`define MSL_LD_READBACK 5'h07
`define MSL_FB_EXT 3'h6

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define MSL_EVENT_CYCLES 4'h4

`endif

/* File: design/msl_pkg.sv */
// Purpose: types shared by the mode, sync and lock-pin control block
// Assumes: field widths as in the register map
// Notes: constants sit in msl_cfg.svh
package msl_pkg;

	// mode and sync register fields
	typedef struct packed {
		logic [4:0] mode;
		logic sync_en;
		logic [5:0] mask;
		logic [1:0] sync_src;
		logic qual;
		logic pol;
		logic auto_sync;
		logic [2:0] sync_type;
		logic xtal;
	} msl_r11_t;

	// lock pin register fields
	typedef struct packed {
		logic [4:0] ld_src;
		logic [2:0] lock_pin_io_kind;
	} msl_r12_t;

	// status sources for the lock pin
	typedef struct packed {
		logic loop1_lock;
		logic loop2_lock;
		logic holdover;
		logic dac_locked;
		logic dac_rail;
		logic dac_low;
		logic dac_high;
		logic [7:0] div_mon;
	} msl_stat_t;

	// decoded operating mode
	typedef struct packed {
		logic valid;
		logic loop1_on;
		logic loop2_on;
		logic ext_osc;
		logic zero_delay;
		logic osc_ref_loop2;
		logic ref2_to_groups;
		logic osc_to_buffer;
		logic osc_to_groups34;
	} msl_mode_dec_t;

	// command from register side to sync control
	typedef struct packed {
		logic en;
		logic req;
		logic ev;
		logic qual;
		logic [5:0] mask;
	} msl_sync_cmd_t;

endpackage : msl_pkg

/* File: design/msl_sync_ctrl.sv */
// Purpose: sync event timing, group hold-low and delay apply
// Assumes: qual_tick_i is a one-cycle pulse in the mclk_i domain
// Notes: event pulse length is a fixed count of system cycles
`timescale 1ns/1ps
`default_nettype none
`include "msl_cfg.svh"

module msl_sync_ctrl (
	// clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	// command
	input wire msl_pkg::msl_sync_cmd_t cmd_i,
	input wire logic qual_tick_i,
	// group controls
	output logic sync_active_o,
	output logic [5:0] hold_low_o,
	output logic [5:0] delay_apply_o
);
	import msl_pkg::*;

	logic [3:0] ev_cnt_ff;
	logic active_ff;
	logic [5:0] mask_cap_ff;
	logic [5:0] hold_ff;
	logic [5:0] apply_ff;
	logic asserted;
	logic nxt_active;

	// ---------------------------------------------------------------
	// event stretch and qualification
	// ---------------------------------------------------------------
	// an event holds sync for a few cycles so groups see a clean low
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ev_cnt_ff <= 4'h0;
		end else if (cmd_i.ev) begin
			ev_cnt_ff <= `MSL_EVENT_CYCLES;
		end else if (ev_cnt_ff != 4'h0) begin
			ev_cnt_ff <= ev_cnt_ff - 4'h1;
		end
	end

	assign asserted = cmd_i.en && (cmd_i.req || ev_cnt_ff != 4'h0);
	// qualified sync only moves on the selected output's edge; clearing enable drops it at once
	assign nxt_active = !cmd_i.en ? 1'b0
		: (!cmd_i.qual || qual_tick_i) ? asserted : active_ff;

	// state, mask capture and group controls
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			active_ff <= 1'b0;
			mask_cap_ff <= 6'h00;
			hold_ff <= 6'h00;
			apply_ff <= 6'h00;
		end else begin
			active_ff <= nxt_active;
			apply_ff <= 6'h00;
			if (nxt_active && !active_ff) begin
				mask_cap_ff <= cmd_i.mask;
				hold_ff <= ~cmd_i.mask;
			end else if (!nxt_active) begin
				hold_ff <= 6'h00;
			end
			if (!nxt_active && active_ff) begin
				apply_ff <= ~mask_cap_ff;
			end
		end
	end

	assign sync_active_o = active_ff;
	assign hold_low_o = hold_ff;
	assign delay_apply_o = apply_ff;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_disabled_idle;
		@(posedge mclk_i) disable iff (!nrst_i)
		!cmd_i.en |=> !active_ff;
	endproperty
	a_disabled_idle: assert property (p_disabled_idle) else $error("sync active while disabled");

	property p_req_holds;
		@(posedge mclk_i) disable iff (!nrst_i)
		(cmd_i.en && cmd_i.req && !cmd_i.qual) |=> (active_ff && hold_ff == ~mask_cap_ff);
	endproperty
	a_req_holds: assert property (p_req_holds) else $error("unmasked groups not held low");

	property p_mask_spares;
		@(posedge mclk_i) disable iff (!nrst_i)
		$rose(active_ff) |-> hold_ff == ~$past(cmd_i.mask);
	endproperty
	a_mask_spares: assert property (p_mask_spares) else $error("masked group was held");

	property p_apply_once;
		@(posedge mclk_i) disable iff (!nrst_i)
		$fell(active_ff) |-> (apply_ff == ~$past(mask_cap_ff)) ##1 (apply_ff == 6'h00);
	endproperty
	a_apply_once: assert property (p_apply_once) else $error("delay apply wrong");

	property p_qual_wait;
		@(posedge mclk_i) disable iff (!nrst_i)
		(cmd_i.en && cmd_i.qual && !qual_tick_i) |=> $stable(active_ff);
	endproperty
	a_qual_wait: assert property (p_qual_wait) else $error("qualified sync moved off edge");

	property p_event_len;
		@(posedge mclk_i) disable iff (!nrst_i)
		(cmd_i.ev && cmd_i.en && !cmd_i.qual) ##1 cmd_i.en [*4] |-> active_ff;
	endproperty
	a_event_len: assert property (p_event_len) else $error("event too short");

endmodule : msl_sync_ctrl
`default_nettype wire

/* File: design/msl_top.sv */
// Purpose: mode, sync and lock-pin control with its serial register port
// Assumes: serial clock, data and latch enable come from another domain
// Notes: frames are 32 bits MSB first, the low five bits are the address
`timescale 1ns/1ps
`default_nettype none
`include "msl_cfg.svh"

module msl_top (
	// clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	// three-wire serial port
	input wire logic ser_clk_i,
	input wire logic ser_data_i,
	input wire logic serial_latch_enable_i,
	// sync pin
	input wire logic sync_pin_i,
	output logic sync_pin_o,
	output logic sync_pin_oe_n_o,
	output logic sync_pull_up_o,
	output logic sync_pull_down_o,
	// lock pin
	output logic lock_status_pin_o,
	output logic lock_status_pin_oe_n_o,
	// status sources
	input wire msl_pkg::msl_stat_t stat_i,
	// qualifying clocks, one-cycle edge pulses
	input wire logic [2:0] fb_sel_i,
	input wire logic [5:0] group_edge_i,
	input wire logic ext_fb_edge_i,
	// controls to the clock path
	output msl_pkg::msl_mode_dec_t mode_o,
	output logic sync_power_o,
	output logic sync_active_o,
	output logic [5:0] group_hold_low_o,
	output logic [5:0] delay_apply_o,
	output logic group2_divider_keep_on_o,
	output logic crystal_amplifier_enable_o
);
	import msl_pkg::*;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	localparam int PW = 19;
	logic [PW-1:0] pin_meta_ff;
	logic [PW-1:0] pin_sync_ff;
	logic [PW-1:0] pin_prev_ff;
	logic sclk_rise;
	logic sclk_fall;
	logic le_rise;
	logic le_fall;
	msl_stat_t stat_s;

	// two stages before any logic looks at a pin
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_meta_ff <= '0;
			pin_sync_ff <= '0;
			pin_prev_ff <= '0;
		end else begin
			pin_meta_ff <= {stat_i, sync_pin_i, serial_latch_enable_i, ser_data_i, ser_clk_i};
			pin_sync_ff <= pin_meta_ff;
			pin_prev_ff <= pin_sync_ff;
		end
	end

	assign sclk_rise = pin_sync_ff[0] && !pin_prev_ff[0];
	assign sclk_fall = !pin_sync_ff[0] && pin_prev_ff[0];
	assign le_rise = pin_sync_ff[2] && !pin_prev_ff[2];
	assign le_fall = !pin_sync_ff[2] && pin_prev_ff[2];
	assign stat_s = pin_sync_ff[PW-1:4];

	// ---------------------------------------------------------------
	// serial shift and register file
	// ---------------------------------------------------------------
	logic [31:0] shift_ff;
	logic [31:0] rb_ff;
	logic [4:0] last_addr_ff;
	logic div_pend_ff;
	msl_r11_t r11_ff;
	msl_r12_t r12_ff;
	logic en_prev_ff;
	logic ev_ff;

	// data is taken on serial clock rising edges while latch enable is low
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			shift_ff <= 32'h0000_0000;
		end else if (sclk_rise && !pin_sync_ff[2]) begin
			shift_ff <= {shift_ff[30:0], pin_sync_ff[1]};
		end
	end

	// latch enable rising commits the frame
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r11_ff <= '0;
			r11_ff.sync_en <= `MSL_RST_SYNC_EN;
			r12_ff <= '0;
			last_addr_ff <= 5'h00;
		end else if (le_rise) begin
			last_addr_ff <= shift_ff[4:0];
			if (shift_ff[4:0] == `MSL_ADDR_MODE_SYNC) begin
				r11_ff.mode <= shift_ff[`MSL_MODE_HI:`MSL_MODE_LO];
				r11_ff.sync_en <= shift_ff[`MSL_EN_BIT];
				r11_ff.mask <= shift_ff[`MSL_MASK_HI:`MSL_MASK_LO];
				r11_ff.sync_src <= shift_ff[`MSL_SRC_HI:`MSL_SRC_LO];
				r11_ff.qual <= shift_ff[`MSL_QUAL_BIT];
				r11_ff.pol <= shift_ff[`MSL_POL_BIT];
				r11_ff.auto_sync <= shift_ff[`MSL_AUTO_BIT];
				r11_ff.sync_type <= shift_ff[`MSL_STYPE_HI:`MSL_STYPE_LO];
				r11_ff.xtal <= shift_ff[`MSL_XTAL_BIT];
			end
			if (shift_ff[4:0] == `MSL_ADDR_LOCK_PIN) begin
				r12_ff.ld_src <= shift_ff[`MSL_LDSRC_HI:`MSL_LDSRC_LO];
				r12_ff.lock_pin_io_kind <= shift_ff[`MSL_LDTYPE_HI:`MSL_LDTYPE_LO];
			end
		end
	end

	// a divider/delay write waits for latch enable falling to fire its sync
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_pend_ff <= 1'b0;
		end else if (le_rise) begin
			div_pend_ff <= (shift_ff[4:0] <= `MSL_ADDR_DIV_LAST);
		end else if (le_fall) begin
			div_pend_ff <= 1'b0;
		end
	end

	// events: enable rising, or an automatic sync on latch enable falling
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			en_prev_ff <= `MSL_RST_SYNC_EN;
			ev_ff <= 1'b0;
		end else begin
			en_prev_ff <= r11_ff.sync_en;
			ev_ff <= (r11_ff.sync_en && !en_prev_ff)
				|| (le_fall && div_pend_ff && r11_ff.auto_sync);
		end
	end

	// readback image of the last addressed register, shifted out MSB first
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rb_ff <= 32'h0000_0000;
		end else if (le_fall) begin
			rb_ff <= 32'h0000_0000;
			if (last_addr_ff == `MSL_ADDR_MODE_SYNC) begin
				rb_ff <= {r11_ff.mode, r11_ff.sync_en, r11_ff.mask, r11_ff.sync_src,
					r11_ff.qual, r11_ff.pol, r11_ff.auto_sync, r11_ff.sync_type,
					6'h00, r11_ff.xtal, 5'h00};
			end else if (last_addr_ff == `MSL_ADDR_LOCK_PIN) begin
				rb_ff <= {r12_ff.ld_src, r12_ff.lock_pin_io_kind, 24'h00_0000};
			end
		end else if (sclk_fall) begin
			rb_ff <= {rb_ff[30:0], 1'b0};
		end
	end

	// ---------------------------------------------------------------
	// pin drive helper
	// ---------------------------------------------------------------
	// returns {level, enable_n}; open kinds release the pin on one level
	function automatic logic [1:0] pin_drive(input logic [2:0] kind, input logic src);
		logic [1:0] r;
		r = 2'b01;
		unique case (kind)
			`MSL_PIN_OUT: r = {src, 1'b0};
			`MSL_PIN_OUT_INV: r = {~src, 1'b0};
			`MSL_PIN_OPEN_SRC: r = {1'b1, ~src};
			`MSL_PIN_OPEN_DRN: r = {1'b0, src};
			default: r = 2'b01;
		endcase
		return r;
	endfunction : pin_drive

	// ---------------------------------------------------------------
	// sync pin and sync request
	// ---------------------------------------------------------------
	logic sync_is_out;
	logic sync_src_bit;
	logic [1:0] sync_drv;
	logic sync_req_ff;
	logic [5:0] out_hold;
	logic [5:0] out_apply;
	logic out_active;
	logic qual_tick;
	msl_sync_cmd_t cmd;

	assign sync_is_out = r11_ff.sync_type >= `MSL_PIN_OUT && r11_ff.sync_type <= `MSL_PIN_OPEN_DRN;
	// reserved source codes read as low
	assign sync_src_bit = (r11_ff.sync_src == `MSL_SSRC_READBACK) ? rb_ff[31] : 1'b0;
	assign sync_drv = pin_drive(r11_ff.sync_type, sync_src_bit);

	// output kinds force the pin term to 0 so only polarity remains
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync_req_ff <= 1'b0;
		end else begin
			sync_req_ff <= (sync_is_out ? 1'b0 : pin_sync_ff[3]) ^ r11_ff.pol;
		end
	end

	// pick the qualifying edge; code 7 gives none
	always_comb begin
		qual_tick = 1'b0;
		if (fb_sel_i < `MSL_FB_EXT) begin
			qual_tick = group_edge_i[fb_sel_i];
		end else if (fb_sel_i == `MSL_FB_EXT) begin
			qual_tick = ext_fb_edge_i;
		end
	end

	assign cmd = '{en: r11_ff.sync_en, req: sync_req_ff, ev: ev_ff, qual: r11_ff.qual,
		mask: r11_ff.mask};

	msl_sync_ctrl u_sync (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.cmd_i(cmd),
		.qual_tick_i(qual_tick),
		.sync_active_o(out_active),
		.hold_low_o(out_hold),
		.delay_apply_o(out_apply)
	);

	assign sync_active_o = out_active;
	assign group_hold_low_o = out_hold;
	assign delay_apply_o = out_apply;

	// ---------------------------------------------------------------
	// lock pin source
	// ---------------------------------------------------------------
	logic ld_src_bit;

	always_comb begin
		ld_src_bit = 1'b0;
		unique case (r12_ff.ld_src)
			5'h01: ld_src_bit = stat_s.loop1_lock;
			5'h02: ld_src_bit = stat_s.loop2_lock;
			5'h03: ld_src_bit = stat_s.loop1_lock && stat_s.loop2_lock;
			5'h04: ld_src_bit = stat_s.holdover;
			5'h05: ld_src_bit = stat_s.dac_locked;
			`MSL_LD_READBACK: ld_src_bit = rb_ff[31];
			5'h08: ld_src_bit = stat_s.dac_rail;
			5'h09: ld_src_bit = stat_s.dac_low;
			5'h0A: ld_src_bit = stat_s.dac_high;
			default: begin
				if (r12_ff.ld_src >= `MSL_LD_DIV_FIRST && r12_ff.ld_src <= `MSL_LD_DIV_LAST) begin
					ld_src_bit = stat_s.div_mon[3'(r12_ff.ld_src - `MSL_LD_DIV_FIRST)];
				end
			end
		endcase
	end

	// ---------------------------------------------------------------
	// registered outputs
	// ---------------------------------------------------------------
	msl_mode_dec_t nxt_mode;

	// reserved modes give an invalid decode with everything off
	always_comb begin
		nxt_mode = '0;
		unique case (r11_ff.mode)
			`MSL_MODE_DUAL_INT, `MSL_MODE_DUAL_INT_ZD, `MSL_MODE_DUAL_EXT,
			`MSL_MODE_DUAL_EXT_ZD: begin
				nxt_mode.loop1_on = 1'b1;
				nxt_mode.loop2_on = 1'b1;
			end
			`MSL_MODE_SGL_INT, `MSL_MODE_SGL_INT_ZD, `MSL_MODE_SGL_EXT: begin
				nxt_mode.loop2_on = 1'b1;
				nxt_mode.osc_ref_loop2 = 1'b1;
			end
			`MSL_MODE_DISTRIB: begin
				nxt_mode.ref2_to_groups = 1'b1;
				nxt_mode.osc_to_buffer = 1'b1;
				nxt_mode.osc_to_groups34 = 1'b1;
			end
			default: nxt_mode.valid = 1'b0;
		endcase
		nxt_mode.valid = nxt_mode.loop2_on || nxt_mode.osc_to_buffer;
		nxt_mode.ext_osc = r11_ff.mode == `MSL_MODE_DUAL_EXT || r11_ff.mode == `MSL_MODE_DUAL_EXT_ZD
			|| r11_ff.mode == `MSL_MODE_SGL_EXT;
		nxt_mode.zero_delay = r11_ff.mode == `MSL_MODE_DUAL_INT_ZD
			|| r11_ff.mode == `MSL_MODE_DUAL_EXT_ZD || r11_ff.mode == `MSL_MODE_SGL_INT_ZD;
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode_o <= '0;
			sync_power_o <= 1'b0;
			group2_divider_keep_on_o <= 1'b0;
			crystal_amplifier_enable_o <= 1'b0;
			{sync_pin_o, sync_pin_oe_n_o} <= 2'b01;
			sync_pull_up_o <= 1'b0;
			sync_pull_down_o <= 1'b0;
			{lock_status_pin_o, lock_status_pin_oe_n_o} <= 2'b01;
		end else begin
			mode_o <= nxt_mode;
			sync_power_o <= r11_ff.sync_en;
			group2_divider_keep_on_o <= r11_ff.qual;
			crystal_amplifier_enable_o <= r11_ff.xtal;
			{sync_pin_o, sync_pin_oe_n_o} <= sync_drv;
			sync_pull_up_o <= r11_ff.sync_type == `MSL_PIN_IN_PU;
			sync_pull_down_o <= r11_ff.sync_type == `MSL_PIN_IN_PD;
			{lock_status_pin_o, lock_status_pin_oe_n_o} <= pin_drive(r12_ff.lock_pin_io_kind, ld_src_bit);
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_ld_inverted_low;
		@(posedge mclk_i) disable iff (!nrst_i)
		(r12_ff.ld_src == 5'h00 && r12_ff.lock_pin_io_kind == `MSL_PIN_OUT_INV)
			|=> (lock_status_pin_o && !lock_status_pin_oe_n_o);
	endproperty
	a_ld_inverted_low: assert property (p_ld_inverted_low) else $error("lock pin not high");

	property p_out_forces_pin;
		@(posedge mclk_i) disable iff (!nrst_i)
		(sync_is_out && !r11_ff.pol) |=> !sync_req_ff;
	endproperty
	a_out_forces_pin: assert property (p_out_forces_pin) else $error("sync input not forced");

	property p_single_loop;
		@(posedge mclk_i) disable iff (!nrst_i)
		(r11_ff.mode == `MSL_MODE_SGL_INT) |=> (!mode_o.loop1_on && mode_o.loop2_on
			&& mode_o.osc_ref_loop2);
	endproperty
	a_single_loop: assert property (p_single_loop) else $error("single loop decode wrong");

	property p_distrib;
		@(posedge mclk_i) disable iff (!nrst_i)
		(r11_ff.mode == `MSL_MODE_DISTRIB) |=> (mode_o.ref2_to_groups && mode_o.osc_to_buffer
			&& !mode_o.loop2_on);
	endproperty
	a_distrib: assert property (p_distrib) else $error("distribution decode wrong");

	property p_auto_on_fall;
		@(posedge mclk_i) disable iff (!nrst_i)
		(le_fall && div_pend_ff && r11_ff.auto_sync) |=> ev_ff;
	endproperty
	a_auto_on_fall: assert property (p_auto_on_fall) else $error("auto sync missed");

	property p_en_rise_event;
		@(posedge mclk_i) disable iff (!nrst_i)
		$rose(r11_ff.sync_en) |=> ev_ff;
	endproperty
	a_en_rise_event: assert property (p_en_rise_event) else $error("enable rise without event");

endmodule : msl_top
`default_nettype wire

/* File: test/msl_host.sv */
// Purpose: host model driving the three-wire serial port
// Assumes: mclk at 10 MHz, serial clock period 900 ns
// Notes: serial clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module msl_host (
	// clock
	input wire logic mclk_i,
	// serial pins
	output logic ser_clk_o,
	output logic ser_data_o,
	output logic le_o
);
	// idle levels
	initial begin
		ser_clk_o = 1'b0;
		ser_data_o = 1'b0;
		le_o = 1'b0;
	end
	// one frame msb first; returns one cycle after latch enable falls
	task automatic send(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			@(posedge mclk_i) ser_data_o <= w[i];
			repeat (4) @(posedge mclk_i);
			ser_clk_o <= 1'b1;
			repeat (4) @(posedge mclk_i);
			ser_clk_o <= 1'b0;
		end
		repeat (4) @(posedge mclk_i);
		le_o <= 1'b1;
		ser_data_o <= ~w[0]; // data not held past the frame
		repeat (8) @(posedge mclk_i);
		le_o <= 1'b0;
		@(posedge mclk_i);
	endtask : send
endmodule : msl_host
`default_nettype wire

/* File: test/mode_sync_lockdetect_ctrl_test.sv */
// Purpose: bench for the mode, sync and lock-pin block
// Assumes: host model owns the serial pins
// Notes: outputs are sampled on the falling edge
`timescale 1ns/1ps
`default_nettype none
module mode_sync_lockdetect_ctrl_test;
	import msl_pkg::*;
	logic mclk, nrst, sck, sdat, le, spin, s_o, s_oe_n, l_o, l_oe_n, act, xtal, pwr;
	logic [5:0] hold, dapp, gedge;
	logic [2:0] fsel;
	logic pu, pd, keep;
	msl_stat_t stat;
	msl_mode_dec_t mode;
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	msl_host h (.mclk_i(mclk), .ser_clk_o(sck), .ser_data_o(sdat), .le_o(le));
	msl_top i_dut (.mclk_i(mclk), .nrst_i(nrst), .ser_clk_i(sck), .ser_data_i(sdat),
		.serial_latch_enable_i(le), .sync_pin_i(spin), .sync_pin_o(s_o),
		.sync_pin_oe_n_o(s_oe_n), .sync_pull_up_o(pu), .sync_pull_down_o(pd),
		.lock_status_pin_o(l_o), .lock_status_pin_oe_n_o(l_oe_n), .stat_i(stat),
		.fb_sel_i(fsel), .group_edge_i(gedge), .ext_fb_edge_i(1'b0), .mode_o(mode),
		.sync_power_o(pwr), .sync_active_o(act), .group_hold_low_o(hold),
		.delay_apply_o(dapp), .group2_divider_keep_on_o(keep),
		.crystal_amplifier_enable_o(xtal));
	// 10 MHz clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic conclude();
		if (num_errors == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : conclude
	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask : chk
	function automatic logic [31:0] r11(logic [4:0] md, logic en, logic [5:0] mk, logic pol,
		logic au, logic [2:0] ty);
		return {md, en, mk, 2'h0, 1'b0, pol, au, ty, 6'h00, 1'b0, 5'h0B};
	endfunction : r11
	// bounded wait for the sync level
	task automatic wait_act(input logic v, input int lim);
		int n = 0;
		while (act !== v && n < lim) begin
			@(negedge mclk);
			n++;
		end
		chk(act === v, "sync level");
	endtask : wait_act
	task automatic t_mode();
		logic [4:0] c;
		logic v;
		logic [8:0] e;
		for (int i = 0; i < 18; i++) begin
			c = 5'(i);
			v = c inside {5'h00, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0B, 5'h10};
			e = {v, v && c < 5'h06, v && c != 5'h10, c inside {5'h03, 5'h05, 5'h0B},
				c inside {5'h02, 5'h05, 5'h08}, c inside {5'h06, 5'h08, 5'h0B}, {3{c == 5'h10}}};
			h.send(r11(c, 1'b1, 6'h00, 1'b0, 1'b0, 3'h0));
			@(negedge mclk);
			chk(mode === e, "mode decode");
		end
		h.send({27'h0000000, 5'h0D});
		@(negedge mclk);
		chk(mode.valid === 1'b0, "unmapped write");
	endtask : t_mode
	task automatic t_auto();
		int n = 0;
		h.send(r11(5'h00, 1'b1, 6'h03, 1'b0, 1'b1, 3'h0));
		h.send(32'h0000_0002);
		wait_act(1'b1, 8);
		chk(hold === 6'h3C, "hold mask");
		while (dapp === 6'h00 && n < 20) begin
			@(negedge mclk);
			n++;
		end
		chk(dapp === 6'h3C && act === 1'b0, "delay apply");
		h.send(r11(5'h00, 1'b0, 6'h00, 1'b0, 1'b1, 3'h0));
		h.send(32'h0000_0002);
		n = 0;
		repeat (12) begin
			@(negedge mclk);
			n += (act !== 1'b0);
		end
		chk(n == 0, "sync while off");
		fork
			h.send(r11(5'h00, 1'b1, 6'h01, 1'b0, 1'b0, 3'h0));
			wait_act(1'b1, 400);
		join
		chk(hold === 6'h3E, "enable event");
	endtask : t_auto
	task automatic t_pol();
		h.send(r11(5'h00, 1'b1, 6'h00, 1'b1, 1'b0, 3'h3));
		wait_act(1'b1, 40);
		@(posedge mclk) spin <= 1'b1;
		repeat (10) @(negedge mclk);
		chk(act === 1'b1 && s_oe_n === 1'b0 && s_o === 1'b0, "pin out");
		h.send(r11(5'h00, 1'b1, 6'h00, 1'b0, 1'b0, 3'h4) | 32'h20);
		wait_act(1'b0, 40);
		chk(s_o === 1'b1 && xtal === 1'b1, "pin inverted");
		h.send(r11(5'h00, 1'b1, 6'h00, 1'b0, 1'b0, 3'h1));
		wait_act(1'b1, 40);
		chk(s_oe_n === 1'b1 && pu === 1'b1, "pin input");
		@(posedge mclk) spin <= 1'b0;
		wait_act(1'b0, 40);
	endtask : t_pol
	task automatic t_qual();
		@(posedge mclk) fsel <= 3'h2;
		h.send(r11(5'h00, 1'b1, 6'h00, 1'b1, 1'b0, 3'h2) | 32'h0002_0000);
		repeat (10) @(negedge mclk);
		chk(act === 1'b0 && keep === 1'b1 && pd === 1'b1, "qual wait");
		@(posedge mclk) gedge <= 6'h04;
		@(posedge mclk) gedge <= 6'h00;
		@(negedge mclk);
		chk(act === 1'b1, "qual edge");
		h.send(r11(5'h10, 1'b1, 6'h00, 1'b0, 1'b0, 3'h3) | 32'h000C_0000);
		repeat (6) @(negedge mclk);
		chk(s_o === 1'b1 && act === 1'b0, "readback on pin");
	endtask : t_qual
	task automatic t_lock();
		logic [8:0] tl [8] = '{9'h006, 9'h009, 9'h017, 9'h036, 9'h048, 9'h0B7, 9'h066, 9'h029};
		@(posedge mclk) stat <= 15'h5001;
		foreach (tl[i]) begin
			h.send({tl[i][8:1], 19'h00000, 5'h0C});
			repeat (6) @(negedge mclk);
			chk(l_o === tl[i][0] && l_oe_n === 1'b0, "lock pin");
		end
	endtask : t_lock
	// hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			conclude();
		end
	end
	initial begin
		nrst = 1'b0;
		spin = 1'b0;
		stat = '0;
		fsel = 3'h7;
		gedge = 6'h00;
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		repeat (4) @(negedge mclk);
		chk(pwr === 1'b1 && mode[8:6] === 3'b111 && act === 1'b0, "reset");
		t_mode();
		t_auto();
		t_pol();
		t_qual();
		t_lock();
		conclude();
	end
endmodule : mode_sync_lockdetect_ctrl_test
`default_nettype wire
